// >>> rtl/flash_cmd_defines.svh
`ifndef FLASH_CMD_DEFINES_SVH
`define FLASH_CMD_DEFINES_SVH
`define REC_MISC_READ 8'h03
`define REC_ERASE 8'h04
`define REC_SECTOR_CRC 8'h05
`define REC_GLOBAL_CRC 8'h06
`define REC_BAUD_LOAD 8'h07
`define REC_RESET 8'h08
`define LEN_MISC_READ 8'h01
`define LEN_ERASE 8'h03
`define LEN_SECTOR_CRC 8'h01
`define LEN_GLOBAL_CRC 8'h00
`define LEN_BAUD_LOAD 8'h02
`define LEN_RESET 8'h00
`define SEL_ERASE_SECTOR 8'h01
`define SEL_ERASE_PAGE 8'h00
`define SUB_CFG1 5'h00
`define SUB_CFG2 5'h01
`define SUB_BOOT_VECTOR_BYTE 5'h02
`define SUB_STATUS 5'h03
`define SUB_SEC_BASE 5'h08
`define SUB_MFR 5'h10
`define SUB_DEV 5'h11
`define SUB_DERIV 5'h12
`define AUTH_KEY 8'h96
`define AUTH_KEY_ADDR 8'hFF
`define FCMD_SET_WE 8'h08
`define FCMD_CLR_WE 8'h0B
`define WE_ACT_BIT 7
`define CHAR_ACK 8'h2E
`define CHAR_NAK 8'h58
`define MAX_DATA 7
`endif

// >>> rtl/flash_cmd_pkg.sv
`default_nettype none
package flash_cmd_pkg;
  typedef struct packed {
    logic [7:0] count;
    logic [15:0] addr;
    logic [7:0] rtype;
  } rec_head_t;
  typedef struct packed {
    logic [7:0] cfg1;
    logic [7:0] cfg2;
    logic [7:0] boot_vec;
    logic [7:0] boot_stat;
    logic [63:0] security;
  } cfg_bytes_t;
  typedef enum logic [5:0] {
    ST_HEAD = 6'h01,
    ST_DATA = 6'h02,
    ST_SUM = 6'h04,
    ST_EXEC = 6'h08,
    ST_WAIT = 6'h10,
    ST_REPLY = 6'h20
  } cmd_state_t;
endpackage
`default_nettype wire

// >>> rtl/flash_program_command_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_defines.svh"
module flash_program_command_unit #(
  parameter logic [7:0] MFR_ID = 8'hA5, // Arbitrary value
  parameter logic [7:0] DEV_ID = 8'h5A, // Arbitrary value
  parameter logic [7:0] DERIV_ID = 8'h3C // Arbitrary value
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  output logic tx_valid,
  output logic [7:0] tx_byte,
  input wire logic tx_ready,
  input wire flash_cmd_pkg::cfg_bytes_t cfg_bytes,
  input wire logic serial_loader_mode,
  input wire logic in_application_mode,
  output logic erase_req,
  output logic erase_sector,
  output logic [15:0] erase_addr,
  output logic crc_req,
  output logic crc_global,
  output logic [7:0] crc_sector,
  input wire logic op_done,
  input wire logic [31:0] crc_result,
  output logic baud_load,
  output logic [15:0] baud_reload,
  output logic mcu_reset,
  input wire logic fcr_wr,
  input wire logic [7:0] fcr_wdata,
  input wire logic fdr_wr,
  input wire logic [7:0] fdr_wdata,
  input wire logic ram_wr,
  input wire logic [7:0] ram_addr,
  input wire logic [7:0] ram_wdata,
  input wire logic iap_call,
  input wire logic iap_needs_key,
  input wire logic iap_write_done,
  output logic iap_go,
  output logic write_enable,
  output logic write_allowed
);
  flash_cmd_pkg::cmd_state_t state_q;
  flash_cmd_pkg::rec_head_t head_q;
  logic [7:0] data_q [0:`MAX_DATA];
  logic [2:0] idx_q;
  logic [7:0] sum_q;
  logic [7:0] reply_q [0:4];
  logic [2:0] rlen_q;
  logic [2:0] rptr_q;
  logic we_q;
  logic we_armed_q;
  logic we_disarm_q;
  logic [7:0] key_q;
  logic key_fault;

  function automatic logic [7:0] read_sub(input logic [7:0] s);
    logic [7:0] r;
    r = 8'h00;
    if (s[7:5] == 3'h0) begin
      case (s[4:0])
        `SUB_CFG1: r = cfg_bytes.cfg1;
        `SUB_CFG2: r = cfg_bytes.cfg2;
        `SUB_BOOT_VECTOR_BYTE: r = cfg_bytes.boot_vec;
        `SUB_STATUS: r = cfg_bytes.boot_stat;
        `SUB_MFR: r = MFR_ID;
        `SUB_DEV: r = DEV_ID;
        `SUB_DERIV: r = DERIV_ID;
        default: begin
          if (s[4:3] == 2'h1) begin
            r = cfg_bytes.security[8'(s[2:0]) * 8 +: 8];
          end
        end
      endcase
    end
    return r; // Reserved codes fall out as zero
  endfunction

  // Header bytes arrive as count, addr hi, addr lo, type; then data, then checksum
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_q <= flash_cmd_pkg::ST_HEAD;
      head_q <= '0;
      idx_q <= 3'h0;
      sum_q <= 8'h00;
      rlen_q <= 3'h0;
      rptr_q <= 3'h0;
      {erase_req, erase_sector, crc_req, crc_global, baud_load, mcu_reset} <= 6'h00;
      erase_addr <= 16'h0000;
      crc_sector <= 8'h00;
      baud_reload <= 16'h0000;
      for (int i = 0; i < 5; i++) reply_q[i] <= 8'h00;
      for (int i = 0; i <= `MAX_DATA; i++) data_q[i] <= 8'h00;
    end else begin
      erase_req <= 1'b0;
      crc_req <= 1'b0;
      baud_load <= 1'b0;
      if (key_fault) mcu_reset <= 1'b1;
      case (state_q)
        flash_cmd_pkg::ST_HEAD: begin
          if (rx_valid) begin
            head_q <= {head_q[23:0], rx_byte};
            sum_q <= sum_q + rx_byte;
            idx_q <= idx_q + 3'h1;
            if (idx_q == 3'h3) begin
              idx_q <= 3'h0;
              state_q <= (head_q[23:16] == 8'h00) ? flash_cmd_pkg::ST_SUM
                                                 : flash_cmd_pkg::ST_DATA;
            end
          end
        end
        flash_cmd_pkg::ST_DATA: begin
          if (rx_valid) begin
            data_q[idx_q] <= rx_byte;
            sum_q <= sum_q + rx_byte;
            idx_q <= idx_q + 3'h1;
            if ({5'h00, idx_q} + 8'h01 == head_q.count) begin
              state_q <= flash_cmd_pkg::ST_SUM;
            end
          end
        end
        flash_cmd_pkg::ST_SUM: begin
          if (rx_valid) begin
            idx_q <= 3'h0;
            rptr_q <= 3'h0;
            rlen_q <= 3'h1;
            state_q <= flash_cmd_pkg::ST_REPLY;
            if (8'(sum_q + rx_byte) != 8'h00) begin
              reply_q[0] <= `CHAR_NAK;
            end else begin
              reply_q[0] <= `CHAR_ACK;
              state_q <= flash_cmd_pkg::ST_EXEC;
            end
          end
        end
        flash_cmd_pkg::ST_EXEC: begin
          state_q <= flash_cmd_pkg::ST_REPLY;
          case (head_q.rtype)
            `REC_MISC_READ: begin
              if (head_q.count == `LEN_MISC_READ) begin
                reply_q[0] <= read_sub(data_q[0]);
              end
            end
            `REC_ERASE: begin
              if (head_q.count == `LEN_ERASE && write_allowed) begin
                erase_req <= 1'b1;
                erase_sector <= (data_q[0] == `SEL_ERASE_SECTOR);
                erase_addr <= {data_q[1], data_q[2]};
                state_q <= flash_cmd_pkg::ST_WAIT;
              end
            end
            `REC_SECTOR_CRC, `REC_GLOBAL_CRC: begin
              crc_req <= 1'b1;
              crc_global <= (head_q.rtype == `REC_GLOBAL_CRC);
              crc_sector <= data_q[0];
              state_q <= flash_cmd_pkg::ST_WAIT;
            end
            `REC_BAUD_LOAD: begin
              if (head_q.count == `LEN_BAUD_LOAD) begin
                baud_load <= 1'b1;
                baud_reload <= {data_q[0], data_q[1]};
              end
            end
            `REC_RESET: begin
              if (head_q.count == `LEN_RESET) mcu_reset <= 1'b1;
            end
            default: ;
          endcase
        end
        flash_cmd_pkg::ST_WAIT: begin
          if (op_done) begin
            if (head_q.rtype == `REC_SECTOR_CRC || head_q.rtype == `REC_GLOBAL_CRC) begin
              {reply_q[0], reply_q[1], reply_q[2], reply_q[3]} <= crc_result;
              reply_q[4] <= `CHAR_ACK;
              rlen_q <= 3'h5;
            end
            state_q <= flash_cmd_pkg::ST_REPLY;
          end
        end
        flash_cmd_pkg::ST_REPLY: begin
          if (tx_ready) begin
            rptr_q <= rptr_q + 3'h1;
            if (rptr_q + 3'h1 == rlen_q) begin
              state_q <= flash_cmd_pkg::ST_HEAD;
              sum_q <= 8'h00;
            end
          end
        end
        default: state_q <= flash_cmd_pkg::ST_HEAD;
      endcase
    end
  end

  assign tx_valid = (state_q == flash_cmd_pkg::ST_REPLY);
  assign tx_byte = reply_q[rptr_q];

  // Write-enable flag; key sequence needs the control write first
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      we_q <= 1'b0;
      we_armed_q <= 1'b0;
      we_disarm_q <= 1'b0;
    end else begin
      if (fcr_wr) begin
        we_armed_q <= (fcr_wdata == `FCMD_SET_WE);
        we_disarm_q <= (fcr_wdata == `FCMD_CLR_WE);
      end
      if (fdr_wr) begin
        we_armed_q <= 1'b0;
        we_disarm_q <= 1'b0;
        if (fdr_wdata == `AUTH_KEY && we_armed_q) we_q <= 1'b1;
        if (fdr_wdata == `AUTH_KEY && we_disarm_q) we_q <= 1'b0;
      end
      if (serial_loader_mode && iap_call) we_q <= 1'b1;
      if (iap_write_done) we_q <= 1'b0;
    end
  end

  assign write_enable = we_q || !cfg_bytes.boot_stat[`WE_ACT_BIT];
  // Other programming modes bypass the flag entirely
  assign write_allowed = write_enable || !(serial_loader_mode || in_application_mode);

  // Authorization key cell shadows RAM location FFH
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      key_q <= 8'h00;
      iap_go <= 1'b0;
    end else begin
      iap_go <= 1'b0;
      if (ram_wr && ram_addr == `AUTH_KEY_ADDR) key_q <= ram_wdata;
      if (iap_call) begin
        key_q <= 8'h00;
        iap_go <= !iap_needs_key || key_q == `AUTH_KEY;
      end
    end
  end

  // Bad key pulls reset through the same output as the reset record
  assign key_fault = iap_call && iap_needs_key && key_q != `AUTH_KEY;

  key_reset_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    key_fault |=> !iap_go && key_q == 8'h00 && mcu_reset)
    else $error("Keyless call was executed");
  key_clear_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    iap_call |=> key_q == 8'h00)
    else $error("Key not cleared after call");
  we_forced_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    !cfg_bytes.boot_stat[`WE_ACT_BIT] |-> write_enable)
    else $error("Write enable not forced");
  nak_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    state_q == flash_cmd_pkg::ST_SUM && rx_valid && 8'(sum_q + rx_byte) != 8'h00
    |=> state_q == flash_cmd_pkg::ST_REPLY && tx_byte == `CHAR_NAK)
    else $error("Bad checksum not rejected");
  no_exec_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (erase_req || crc_req || baud_load) |-> $past(state_q == flash_cmd_pkg::ST_EXEC))
    else $error("Operation before record complete");
  we_set_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    fcr_wr && fcr_wdata == `FCMD_SET_WE && !fdr_wr && !iap_write_done
    ##1 fdr_wr && fdr_wdata == `AUTH_KEY && !fcr_wr && !iap_write_done
    |=> we_q)
    else $error("Set sequence ignored");
  we_clr_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    iap_write_done |=> !we_q)
    else $error("Flag left set after write");
  erase_gate_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    erase_req |-> $past(write_allowed))
    else $error("Erase without write enable");
endmodule // flash_program_command_unit
`default_nettype wire

// >>> verification/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic core_clk,
  output logic rx_valid,
  output logic [7:0] rx_byte,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  output logic tx_ready
);
  int slow = 0; // Stall before taking a reply
  initial begin
    rx_valid = 1'b0;
    rx_byte = 8'hC3;
    tx_ready = 1'b0;
  end
  // Count, don't-care address, type, data, two's-complement sum
  task automatic send(input logic [7:0] cnt, typ, input logic [7:0] d [8], input bit bad);
    logic [7:0] b [13];
    logic [7:0] s;
    b[0] = cnt;
    b[1] = 8'h5A;
    b[2] = 8'hA5;
    b[3] = typ;
    for (int i = 0; i < cnt; i++) b[4+i] = d[i];
    s = 8'h00;
    for (int i = 0; i < 4 + cnt; i++) s = s + b[i];
    b[4+cnt] = 8'h00 - s + {7'h00, bad};
    for (int i = 0; i < 5 + cnt; i++) begin
      @(negedge core_clk);
      rx_valid = 1'b1;
      rx_byte = b[i];
    end
    @(negedge core_clk);
    rx_valid = 1'b0;
    rx_byte = ~rx_byte; // Released line must not look valid
  endtask
  task automatic recv(output logic [7:0] v);
    int t;
    repeat (slow + 1) @(negedge core_clk);
    tx_ready = 1'b1;
    t = 0;
    // Sample at the falling edge, where the reply stands settled
    while (tx_valid !== 1'b1 && t < 300) begin
      @(negedge core_clk);
      t++;
    end
    v = (tx_valid === 1'b1) ? tx_byte : 8'hXX;
    @(negedge core_clk);
    tx_ready = 1'b0;
  endtask
endmodule // host_model
`default_nettype wire

// >>> verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb;
  logic core_clk = 1'b0, reset_n = 1'b0, rx_valid, tx_valid, tx_ready;
  logic [7:0] rx_byte, tx_byte, crc_sector, fcr_wdata, fdr_wdata, ram_addr, ram_wdata, rb;
  logic serial_loader_mode, in_application_mode, erase_req, erase_sector, crc_req, crc_global;
  logic op_done, baud_load, mcu_reset, fcr_wr, fdr_wr, ram_wr, iap_call, iap_needs_key;
  logic iap_write_done, iap_go, write_enable, write_allowed;
  logic [15:0] erase_addr, baud_reload;
  logic [31:0] crc_result;
  flash_cmd_pkg::cfg_bytes_t cfg_bytes;
  int mismatches = 0, n_checks = 0, cyc = 0, er_n = 0, crc_n = 0, bd_n = 0, go_n = 0;
  logic [7:0] subs [10] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h08, 8'h0F, 8'h10, 8'h11, 8'h12};
  logic [7:0] expv [10] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h00, 8'h80, 8'hF7, 8'hC1, 8'hD2, 8'hE3};
  flash_program_command_unit #(.MFR_ID(8'hC1), .DEV_ID(8'hD2), .DERIV_ID(8'hE3)) dut (
    .core_clk, .reset_n, .rx_valid, .rx_byte, .tx_valid, .tx_byte, .tx_ready, .cfg_bytes,
    .serial_loader_mode, .in_application_mode, .erase_req, .erase_sector, .erase_addr,
    .crc_req, .crc_global, .crc_sector, .op_done, .crc_result, .baud_load, .baud_reload,
    .mcu_reset, .fcr_wr, .fcr_wdata, .fdr_wr, .fdr_wdata, .ram_wr, .ram_addr, .ram_wdata,
    .iap_call, .iap_needs_key, .iap_write_done, .iap_go, .write_enable, .write_allowed);
  host_model host (.core_clk, .rx_valid, .rx_byte, .tx_valid, .tx_byte, .tx_ready);
  always #5 core_clk = ~core_clk;
  always @(negedge core_clk) op_done <= erase_req | crc_req;
  always @(posedge core_clk) begin
    if (erase_req === 1'b1) er_n++;
    if (crc_req === 1'b1) crc_n++;
    if (baud_load === 1'b1) bd_n++;
    if (iap_go === 1'b1) go_n++;
    cyc++;
    if (cyc == 9000) begin
      mismatches++;
      test_done();
    end
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic cmd(input logic [7:0] cnt, typ, input logic [7:0] d [8], input bit bad = 0);
    host.send(cnt, typ, d, bad);
    host.recv(rb);
  endtask
  task automatic fwr(input bit ctl, input logic [7:0] v);
    @(negedge core_clk);
    {fcr_wr, fdr_wr, fcr_wdata, fdr_wdata} = {ctl, !ctl, v, v};
    @(negedge core_clk);
    {fcr_wr, fdr_wr} = 2'b00;
    @(negedge core_clk); // Flag lands one edge after the data write
  endtask
  task automatic fseq(input logic [7:0] c, k);
    @(negedge core_clk);
    {fcr_wr, fcr_wdata} = {1'b1, c};
    @(negedge core_clk);
    {fcr_wr, fdr_wr, fdr_wdata} = {1'b0, 1'b1, k};
    @(negedge core_clk);
    fdr_wr = 1'b0;
    @(negedge core_clk);
  endtask
  task automatic pulse(ref logic s);
    @(negedge core_clk);
    s = 1'b1;
    @(negedge core_clk);
    s = 1'b0;
    repeat (2) @(negedge core_clk);
  endtask
  initial begin
    {fcr_wr, fdr_wr, ram_wr, iap_call, iap_needs_key, iap_write_done} = '0;
    {fcr_wdata, fdr_wdata, ram_addr, ram_wdata} = '0;
    cfg_bytes = {8'h11, 8'h22, 8'h33, 8'h44, 64'hF7E6D5C4B3A29180};
    {serial_loader_mode, in_application_mode} = 2'b10;
    crc_result = 32'h1A2B3C4D;
    repeat (12) @(negedge core_clk);
    reset_n = 1'b1;
    foreach (subs[i]) begin
      cmd(8'h01, 8'h03, '{subs[i], 0, 0, 0, 0, 0, 0, 0});
      `CHK("misc read", expv[i], rb)
    end
    cmd(8'h02, 8'h07, '{8'hAB, 8'hCD, 0, 0, 0, 0, 0, 0}, 1);
    `CHK("bad sum", 8'h58, rb)
    `CHK("no baud", 0, bd_n)
    host.slow = 3;
    cmd(8'h02, 8'h07, '{8'hAB, 8'hCD, 0, 0, 0, 0, 0, 0});
    `CHK("baud ack", 8'h2E, rb)
    `CHK("baud", 16'hABCD, baud_reload)
    `CHK("baud n", 1, bd_n)
    cmd(8'h03, 8'h04, '{8'h01, 8'h12, 8'h34, 0, 0, 0, 0, 0});
    `CHK("sector", {1'b1, 16'h1234}, {erase_sector, erase_addr})
    cmd(8'h03, 8'h04, '{8'h00, 8'h56, 8'h78, 0, 0, 0, 0, 0});
    `CHK("page", {1'b0, 16'h5678, 8'h2E}, {erase_sector, erase_addr, rb})
    `CHK("erase n", 2, er_n)
    cmd(8'h01, 8'h05, '{8'h44, 0, 0, 0, 0, 0, 0, 0});
    `CHK("crc sect", 8'h44, crc_sector)
    for (int k = 0; k < 5; k++) begin
      `CHK("crc byte", k < 4 ? crc_result[31-8*k -: 8] : 8'h2E, rb)
      if (k < 4) host.recv(rb);
    end
    host.slow = 0;
    cmd(8'h00, 8'h06, '{0, 0, 0, 0, 0, 0, 0, 0});
    `CHK("crc glob", 1'b1, crc_global)
    repeat (4) host.recv(rb);
    `CHK("crc n", 2, crc_n)
    cmd(8'h00, 8'h09, '{0, 0, 0, 0, 0, 0, 0, 0});
    `CHK("unknown", 8'h2E, rb)
    `CHK("unk side", {2, 2, 1'b0}, {er_n, crc_n, mcu_reset})
    `CHK("we forced", 1'b1, write_enable)
    cfg_bytes.boot_stat[7] = 1'b1;
    fwr(1, 8'h08);
    `CHK("we half", 1'b0, write_enable)
    `CHK("gated", 1'b0, write_allowed)
    cmd(8'h03, 8'h04, '{8'h01, 8'h00, 8'h00, 0, 0, 0, 0, 0});
    `CHK("refused", {2, 8'h2E}, {er_n, rb})
    serial_loader_mode = 1'b0;
    @(negedge core_clk);
    `CHK("ungated", 1'b1, write_allowed)
    in_application_mode = 1'b1;
    fseq(8'h08, 8'h95);
    `CHK("bad key", 1'b0, write_enable)
    fseq(8'h08, 8'h96);
    `CHK("we set", 2'b11, {write_enable, write_allowed})
    pulse(iap_write_done);
    `CHK("we iap clr", 1'b0, write_enable)
    fseq(8'h08, 8'h96);
    fseq(8'h0B, 8'h96);
    `CHK("we clr", 1'b0, write_enable)
    serial_loader_mode = 1'b1;
    pulse(iap_call);
    `CHK("loader we", {1'b1, 1}, {write_enable, go_n})
    serial_loader_mode = 1'b0;
    {ram_addr, ram_wdata, iap_needs_key} = {8'hFF, 8'h96, 1'b1};
    pulse(ram_wr);
    pulse(iap_call);
    `CHK("key go", 2, go_n)
    pulse(iap_call);
    `CHK("key gone", {2, 1'b1}, {go_n, mcu_reset})
    reset_n = 1'b0;
    @(negedge core_clk);
    reset_n = 1'b1;
    iap_needs_key = 1'b0;
    pulse(iap_call);
    `CHK("no key need", {3, 1'b0}, {go_n, mcu_reset})
    cmd(8'h01, 8'h08, '{0, 0, 0, 0, 0, 0, 0, 0});
    `CHK("reset count", 1'b0, mcu_reset)
    host.send(8'h00, 8'h08, '{0, 0, 0, 0, 0, 0, 0, 0}, 0);
    repeat (3) @(negedge core_clk);
    `CHK("mcu reset", 1'b1, mcu_reset)
    fseq(8'h08, 8'h96);
    reset_n = 1'b0;
    @(negedge core_clk);
    reset_n = 1'b1;
    `CHK("rst clr", 2'b00, {write_enable, mcu_reset})
    test_done();
  end
endmodule // tb
`default_nettype wire
